// ==== dv/test_video_sound_dma_bus_interface.sv ====
// both ends joined, driven through the controller's user side
module test_video_sound_dma_bus_interface;
  timeunit 1ns;
  timeprecision 1ns;
  import vsd_pkg::*;

  logic                  clk;             // 10 MHz system clock
  logic                  rst_n;           // active low reset
  logic                  fifo_pop;        // pop one video word
  logic [FIFO_W-1:0]     fifo_word;       // popped word
  logic                  fifo_empty;      // video fifo empty
  logic                  power_down;      // power-down level
  logic [2:0]            out_port_source; // chosen output source
  logic                  async_mode;      // controller bus mode
  logic                  wr_req;          // register write request
  logic [REG_ADDR_W-1:0] wr_addr;         // register address
  logic [REG_DATA_W-1:0] wr_data;         // register value
  logic [DIN_W-1:0]      dma_word;        // data served per beat
  logic                  transfer_status; // vram status level
  logic [1:0]            port_sel;        // port source select
  logic                  busy;            // controller busy
  logic                  vram_transfer_cycle; // transfer cycle seen
  int                    errors;          // mismatches
  int                    total_checks;    // comparisons made
  int                    cycles;          // timeout counter
  int                    snd_reqs;        // sound request falls
  logic                  snd_q;           // last sound request level
  logic [FIFO_W-1:0]     w;               // popped word

  vsd_if bus_if ();

  vsd_device i_vsd_device (
    .clk(clk), .rst_n(rst_n), .bus(bus_if.dev), .fifo_pop(fifo_pop),
    .fifo_word(fifo_word), .fifo_empty(fifo_empty),
    .power_down(power_down), .out_port_source(out_port_source)
  );

  vsd_mem_ctrl i_vsd_mem_ctrl (
    .clk(clk), .rst_n(rst_n), .bus(bus_if.mc), .async_mode(async_mode),
    .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data),
    .dma_word(dma_word), .transfer_status(transfer_status),
    .port_sel(port_sel), .busy(busy),
    .vram_transfer_cycle(vram_transfer_cycle)
  );

  vsd_properties i_vsd_properties (
    .clk(clk), .rst_n(rst_n),
    .memory_bus_clock(bus_if.memory_bus_clock),
    .register_write_strobe_n(bus_if.register_write_strobe_n),
    .video_dma_request_n(bus_if.video_dma_request_n),
    .video_dma_ack_n(bus_if.video_dma_ack_n),
    .sound_dma_request_n(bus_if.sound_dma_request_n),
    .sound_dma_ack_n(bus_if.sound_dma_ack_n),
    .vram_transfer_status(bus_if.vram_transfer_status),
    .ext_register_outputs(bus_if.ext_register_outputs)
  );

  // clock, 100 ns period, running through reset too
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // verdict and end of run
  task automatic give_verdict();
    if (errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // compare and report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one register write through the controller
  task automatic wr_reg(input logic [7:0] a, input logic [23:0] d);
    int n;
    @(posedge clk);
    for (n = 0; n < 100 && busy !== 1'b0; n++) @(posedge clk);
    wr_req  <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge clk);
    for (n = 0; n < 100 && bus_if.register_write_strobe_n !== 1'b0; n++)
      @(posedge clk);
    wr_req <= 1'b0;
    @(posedge clk);
    for (n = 0; n < 100 && busy !== 1'b0; n++) @(posedge clk);
    repeat (6) @(posedge clk);
  endtask

  // pop one video word when available
  task automatic pop_word(output logic [31:0] v);
    int n;
    @(posedge clk);
    for (n = 0; n < 400 && fifo_empty !== 1'b0; n++) @(posedge clk);
    fifo_pop <= 1'b1;
    @(posedge clk);
    fifo_pop <= 1'b0;
    @(posedge clk);
    v = fifo_word;
  endtask

  // drain stale words, then expect the served value
  task automatic run_dma(input logic [31:0] v);
    logic [31:0] x;
    dma_word <= {v, 32'hFFFF_FFFF};
    repeat (16) pop_word(x);
    repeat (4) begin
      pop_word(x);
      check(x, v);
    end
  endtask

  // sound request activity and timeout
  always @(posedge clk) begin
    snd_q <= bus_if.sound_dma_request_n;
    if (snd_q === 1'b1 && bus_if.sound_dma_request_n === 1'b0)
      snd_reqs <= snd_reqs + 1;
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errors++;
      give_verdict();
    end
  end

  initial begin
    int n;
    rst_n = 1'b0; fifo_pop = 1'b0; async_mode = 1'b0; wr_req = 1'b0;
    wr_addr = 8'h00; wr_data = 24'h000000; dma_word = 64'h0;
    transfer_status = 1'b0; port_sel = 2'h0; errors = 0;
    total_checks = 0; cycles = 0; snd_reqs = 0; snd_q = 1'b1;
    repeat (3) @(posedge clk);
    check(power_down, 1'b1);
    check(bus_if.video_dma_request_n, 1'b1);
    check(bus_if.ext_register_outputs, 2'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    check(power_down, 1'b0);
    wr_reg(ADDR_EXTREG, 24'h000003);
    check(bus_if.ext_register_outputs, 2'h3);
    wr_reg(ADDR_EXTREG, 24'h030001);
    check(bus_if.ext_register_outputs, 2'h1);
    wr_reg(8'h10, 24'h000002);
    check(bus_if.ext_register_outputs, 2'h1);
    wr_reg(ADDR_CONTROL, 24'h004000);
    check(power_down, 1'b1);
    wr_reg(ADDR_CONTROL, 24'h000000);
    check(power_down, 1'b0);
    for (int i = 0; i < 4; i++) begin
      port_sel <= 2'(i);
      repeat (6) @(posedge clk);
      check(out_port_source, {1'b0, 2'(i)});
    end
    // short raster so blanking comes round quickly
    wr_reg(ADDR_HTOTAL, 24'h000010);
    wr_reg(ADDR_VDISP, 24'h000004);
    wr_reg(ADDR_VTOTAL, 24'h000008);
    for (n = 0; n < 5000 && bus_if.vertical_blank_flag !== 1'b0; n++)
      @(posedge clk);
    for (n = 0; n < 5000 && bus_if.vertical_blank_flag !== 1'b1; n++)
      @(posedge clk);
    check(bus_if.vertical_blank_flag, 1'b1);
    for (n = 0; n < 5000 && bus_if.vertical_blank_flag !== 1'b0; n++)
      @(posedge clk);
    check(bus_if.vertical_blank_flag, 1'b0);
    // synchronous bus with sound enabled
    wr_reg(ADDR_CONTROL, 24'h000008);
    run_dma(32'h5A5A_0001);
    check(32'(snd_reqs != 0), 32'h1);
    // asynchronous bus
    wr_reg(ADDR_CONTROL, 24'h004008); // park engines before mode change
    async_mode <= 1'b1;
    wr_reg(ADDR_CONTROL, 24'h000009);
    run_dma(32'hC3C3_0002);
    // status edge starts a transfer cycle
    transfer_status <= 1'b1;
    for (n = 0; n < 300 && vram_transfer_cycle !== 1'b1; n++)
      @(posedge clk);
    check(vram_transfer_cycle, 1'b1);
    give_verdict();
  end
endmodule

// ==== dv/vsd_properties.sv ====
// pin-level checks across the controller and the memory controller
module vsd_properties (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       memory_bus_clock,
  input wire logic       register_write_strobe_n,
  input wire logic       video_dma_request_n,
  input wire logic       video_dma_ack_n,
  input wire logic       sound_dma_request_n,
  input wire logic       sound_dma_ack_n,
  input wire logic       vram_transfer_status,
  input wire logic [1:0] ext_register_outputs
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic       bus_q;      // bus clock seen last cycle
  logic       bus_rise;   // bus clock rising this cycle
  logic [3:0] vbeat_q;    // bus clock rises in one video ack window
  logic [3:0] sbeat_q;    // bus clock rises in one sound ack window
  logic       vseen_q;    // video ack seen low during this request
  logic       sseen_q;    // sound ack seen low during this request
  logic [3:0] since_wr_q; // cycles since the write strobe was low

  assign bus_rise = memory_bus_clock & ~bus_q;

  // bus clock edge detect
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) bus_q <= 1'b0;
    else bus_q <= memory_bus_clock;

  // beat counters, cleared while ack is high
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) vbeat_q <= 4'h0;
    else if (video_dma_ack_n) vbeat_q <= 4'h0;
    else if (bus_rise) vbeat_q <= vbeat_q + 4'h1;

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) sbeat_q <= 4'h0;
    else if (sound_dma_ack_n) sbeat_q <= 4'h0;
    else if (bus_rise) sbeat_q <= sbeat_q + 4'h1;

  // ack seen flags, cleared while request is high
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) vseen_q <= 1'b0;
    else if (video_dma_request_n) vseen_q <= 1'b0;
    else if (!video_dma_ack_n) vseen_q <= 1'b1;

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) sseen_q <= 1'b0;
    else if (sound_dma_request_n) sseen_q <= 1'b0;
    else if (!sound_dma_ack_n) sseen_q <= 1'b1;

  // distance from the last write strobe, saturating
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) since_wr_q <= 4'hF;
    else if (!register_write_strobe_n) since_wr_q <= 4'h0;
    else if (since_wr_q != 4'hF) since_wr_q <= since_wr_q + 4'h1;

  sequence s_vid_ack_fall;
    $fell(video_dma_ack_n);
  endsequence
  sequence s_snd_ack_fall;
    $fell(sound_dma_ack_n);
  endsequence

  property p_vid_req_hold;
    $rose(video_dma_request_n) |-> vseen_q;
  endproperty
  property p_vid_req_release;
    s_vid_ack_fall |-> ##[1:8] video_dma_request_n;
  endproperty
  property p_snd_req_hold;
    $rose(sound_dma_request_n) |-> sseen_q;
  endproperty
  property p_snd_req_release;
    s_snd_ack_fall |-> ##[1:8] sound_dma_request_n;
  endproperty
  property p_vid_beats;
    $rose(video_dma_ack_n) |-> (vbeat_q == 4'h4 || vbeat_q == 4'h0);
  endproperty
  property p_snd_beats;
    $rose(sound_dma_ack_n) |-> (sbeat_q == 4'h4 || sbeat_q == 4'h0);
  endproperty
  property p_ext_after_write;
    $changed(ext_register_outputs) |-> since_wr_q < 4'h8;
  endproperty
  property p_status_starts_dma;
    $changed(vram_transfer_status) |-> ##[1:150] !video_dma_request_n;
  endproperty

  a_vid_req_hold: assert property (p_vid_req_hold)
    else $error("video request released before ack");
  a_vid_req_release: assert property (p_vid_req_release)
    else $error("video request not released after ack");
  a_snd_req_hold: assert property (p_snd_req_hold)
    else $error("sound request released before ack");
  a_snd_req_release: assert property (p_snd_req_release)
    else $error("sound request not released after ack");
  a_vid_beats: assert property (p_vid_beats)
    else $error("video dma beat count wrong");
  a_snd_beats: assert property (p_snd_beats)
    else $error("sound dma beat count wrong");
  a_ext_after_write: assert property (p_ext_after_write)
    else $error("ext outputs changed without a write");
  a_status_starts_dma: assert property (p_status_starts_dma)
    else $error("status change did not start video dma");
endmodule

// ==== rtl/vsd_device.sv ====
// Summary of operation
// [RL1] flyback rises on first raster outside display
// [RL2] flyback falls on first active display raster
// [RL3] host updates frame buffer during flyback
// [RL4] write strobe low writes addressed register
// [RL5] reset forces control power-down bit high
// [RL6] clock keeps running while reset held
// [RL7] sound request low, released after ack
// [RL8] each sound request carries four words
// [RL9] host holds sound ack low during dma; in async mode vsd_mem_ctrl pulses it once per word instead
// [RL10] video request low, released after ack
// [RL11] host drives video ack during dma
// [RL12] sync mode: words taken on bus clock
// [RL13] async mode: word per ack falling edge
// [RL14] vram clock only when fifo needs data
// [RL15] host inverts vram clock and returns it
// [RL16] transfer-status edge starts video dma
// [RL17] host treats that dma as transfer
// [RL18] ext bits 17:16 pick sync type, polarity
// [RL19] hsync width programmed in two-pixel steps
// [RL20] ext register bits 1:0 drive pins
// [RL21] port select picks digital output source
// [RL22] bus clock held low in async mode
// [RL23] register data on lower bus half
// [RL24] new request only after previous released
//
// Our own choices: the register offsets and the address-and-strobe port.
module vsd_device (
  input  wire logic            clk,
  input  wire logic            rst_n,
  vsd_if.dev                   bus,
  input  wire logic            fifo_pop,
  output logic [vsd_pkg::FIFO_W-1:0] fifo_word,
  output logic                 fifo_empty,
  output logic                 power_down,
  output logic [2:0]           out_port_source
);
  import vsd_pkg::*;

  // synchronised pins
  logic bclk_s, vak_s, sak_s, strb_s, qsf_s, qret_s;
  logic bclk_p, vak_p, sak_p, qsf_p, qret_p; // previous samples
  vsd_sync2 u_bclk (.clk(clk), .rst_n(rst_n),
    .d(bus.memory_bus_clock), .q(bclk_s));
  vsd_sync2 u_vak (.clk(clk), .rst_n(rst_n),
    .d(bus.video_dma_ack_n), .q(vak_s));
  vsd_sync2 u_sak (.clk(clk), .rst_n(rst_n),
    .d(bus.sound_dma_ack_n), .q(sak_s));
  vsd_sync2 u_strb (.clk(clk), .rst_n(rst_n),
    .d(bus.register_write_strobe_n), .q(strb_s));
  vsd_sync2 u_qsf (.clk(clk), .rst_n(rst_n),
    .d(bus.vram_transfer_status), .q(qsf_s));
  vsd_sync2 u_qret (.clk(clk), .rst_n(rst_n),
    .d(bus.vram_clock_return), .q(qret_s));

  // edge history of synchronised pins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bclk_p <= 1'b0;
      vak_p  <= 1'b1;
      sak_p  <= 1'b1;
      qsf_p  <= 1'b0;
      qret_p <= 1'b0;
    end else begin
      bclk_p <= bclk_s;
      vak_p  <= vak_s;
      sak_p  <= sak_s;
      qsf_p  <= qsf_s;
      qret_p <= qret_s;
    end
  end

  logic bclk_rise, vak_fall, sak_fall, qsf_edge, qret_rise;
  assign bclk_rise = bclk_s & ~bclk_p;
  assign vak_fall  = ~vak_s & vak_p;
  assign sak_fall  = ~sak_s & sak_p;
  assign qsf_edge  = qsf_s ^ qsf_p;          // [RL16]
  assign qret_rise = qret_s & ~qret_p;

  // registers
  logic [REG_DATA_W-1:0] ctl_q, ext_q, hsw_q, vdisp_q, vtot_q, htot_q;
  logic                  strb_p;            // strobe edge history
  logic [REG_ADDR_W-1:0] waddr;
  logic [REG_DATA_W-1:0] wdata;
  assign waddr = bus.din[REG_ADDR_LSB +: REG_ADDR_W];
  assign wdata = bus.din[REG_DATA_W-1:0];

  // one register write per strobe low period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_q   <= '0;
      ext_q   <= '0;
      hsw_q   <= '0;
      vdisp_q <= '0;
      vtot_q  <= '0;
      htot_q  <= '0;
      strb_p  <= 1'b1;
    end else begin
      strb_p <= strb_s;
      if (!strb_s && strb_p) begin          // [RL4]
        case (waddr)
          ADDR_CONTROL: ctl_q   <= wdata;
          ADDR_EXTREG:  ext_q   <= wdata;
          ADDR_HSYNC_W: hsw_q   <= wdata;
          ADDR_VDISP:   vdisp_q <= wdata;
          ADDR_VTOTAL:  vtot_q  <= wdata;
          ADDR_HTOTAL:  htot_q  <= wdata;
          default: ;                        // unmapped: ignored
        endcase
      end
    end
  end

  // reset forces power-down flag, visible from reset
  logic [REG_DATA_W-1:0] ctl_view;
  always_comb begin
    ctl_view = ctl_q;
    if (!rst_n) ctl_view[CTL_PDOWN_BIT] = 1'b1; // [RL5]
  end
  assign power_down = ctl_view[CTL_PDOWN_BIT] | ~rst_n; // [RL5]

  logic async_m, vram_m;
  assign async_m = ctl_q[CTL_ASYNC_BIT];
  assign vram_m  = ctl_q[CTL_VRAM_BIT];

  // raster timing: one clk per two pixels
  logic [TIMER_W-1:0] hcnt_q, vcnt_q;
  logic line_end;
  assign line_end = (hcnt_q >= htot_q[TIMER_W-1:0]);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hcnt_q <= '0;
      vcnt_q <= '0;
    end else if (power_down) begin
      hcnt_q <= '0;
      vcnt_q <= '0;
    end else if (line_end) begin
      hcnt_q <= '0;
      vcnt_q <= (vcnt_q >= vtot_q[TIMER_W-1:0]) ? '0 : vcnt_q + 1'b1;
    end else begin
      hcnt_q <= hcnt_q + 1'b1;
    end
  end

  // flyback flag, changes at start of a raster
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.vertical_blank_flag <= 1'b0;
    end else if (hcnt_q == '0) begin
      bus.vertical_blank_flag <= (vcnt_q >= vdisp_q[TIMER_W-1:0]); // [RL1] [RL2]
    end
  end

  // line sync: width counted in two-pixel units
  logic hs_raw, sync_sel;
  assign hs_raw = (hcnt_q < hsw_q[TIMER_W-1:0]);  // [RL19]
  assign sync_sel = ext_q[EXT_SYNC_SEL_BIT]
                  ? ~(hs_raw | bus.vertical_blank_flag) // composite nor
                  : hs_raw;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.line_sync <= 1'b0;
    end else begin
      bus.line_sync <= sync_sel ^ ext_q[EXT_SYNC_POL_BIT]; // [RL18]
    end
  end

  // external register pins and port source
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.ext_register_outputs <= '0;
      out_port_source          <= '0;
    end else begin
      bus.ext_register_outputs <= ext_q[1:0];  // [RL20]
      out_port_source <= {1'b0, bus.port_source_select}; // [RL21]
    end
  end

  // video fifo
  logic [FIFO_W-1:0]  mem [FIFO_DEPTH];
  logic [FIFO_AW-1:0] wp_q, rp_q, level;
  logic               push;
  assign level      = wp_q - rp_q;
  assign fifo_empty = (level == '0);
  logic need_data;
  assign need_data  = (level <= FIFO_LOW);

  // video dma engine
  vsd_dma_state_t     vst_q;
  logic [CNT_W-1:0]   vcnt_w;
  logic               qsf_pend_q, vid_beat;
  assign vid_beat = async_m ? vak_fall                       // [RL13]
                            : (bclk_rise & ~vak_s);          // [RL12]
  // first async strobe lands while still in the request state
  assign push = (vst_q != VSD_IDLE) && !vram_m && vid_beat
                && bus.video_or_cursor_select
                || (vram_m && qret_rise);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vst_q <= VSD_IDLE;
      vcnt_w <= '0;
      qsf_pend_q <= 1'b0;
      bus.video_dma_request_n <= 1'b1;
      bus.video_or_cursor_select <= 1'b1;
    end else begin
      if (qsf_edge) qsf_pend_q <= 1'b1;
      case (vst_q)
        VSD_IDLE: if (!power_down && vak_s &&               // [RL24]
                      (qsf_pend_q || (!vram_m && need_data)
                       || ctl_q[CTL_CURS_BIT])) begin
          bus.video_dma_request_n <= 1'b0;                   // [RL10]
          bus.video_or_cursor_select <= !ctl_q[CTL_CURS_BIT] || qsf_pend_q;
          qsf_pend_q <= qsf_edge;
          vcnt_w <= '0;
          vst_q <= VSD_REQ;
        end
        VSD_REQ: if (!vak_s) begin
          bus.video_dma_request_n <= 1'b1;                   // [RL10]
          vst_q <= VSD_XFER;
          if (!async_m && bclk_rise) vcnt_w <= vcnt_w + 1'b1;
          else if (async_m && vak_fall) vcnt_w <= vcnt_w + 1'b1;
        end
        VSD_XFER: begin
          if (vid_beat) vcnt_w <= vcnt_w + 1'b1;
          if (vcnt_w == CNT_W'(DMA_WORDS) && vak_s)
            vst_q <= VSD_IDLE;
        end
        default: vst_q <= VSD_IDLE;
      endcase
    end
  end

  // fifo storage and pointers
  always_ff @(posedge clk) begin
    if (push && level != FIFO_AW'(FIFO_DEPTH)) // never overwrite unread
      mem[wp_q[FIFO_AW-2:0]] <= bus.din[DIN_W-1 -: FIFO_W];
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      fifo_word <= '0;
    end else begin
      if (push && level != FIFO_AW'(FIFO_DEPTH)) wp_q <= wp_q + 1'b1;
      if (fifo_pop && !fifo_empty) begin
        fifo_word <= mem[rp_q[FIFO_AW-2:0]];
        rp_q <= rp_q + 1'b1;
      end
    end
  end

  // vram clock runs only while fifo is short
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) bus.vram_clock_out_n <= 1'b1;
    else if (vram_m && need_data && !power_down)
      bus.vram_clock_out_n <= ~bus.vram_clock_out_n;        // [RL14]
    else bus.vram_clock_out_n <= 1'b1;
  end

  // sound dma engine
  vsd_dma_state_t   sst_q;
  logic [CNT_W-1:0] scnt_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sst_q <= VSD_IDLE;
      scnt_q <= '0;
      bus.sound_dma_request_n <= 1'b1;
    end else begin
      case (sst_q)
        VSD_IDLE: if (ctl_q[CTL_SND_BIT] && !power_down && sak_s) begin
          bus.sound_dma_request_n <= 1'b0;                   // [RL7] [RL24]
          scnt_q <= '0;
          sst_q <= VSD_REQ;
        end
        VSD_REQ: if (!sak_s) begin
          bus.sound_dma_request_n <= 1'b1;                   // [RL7]
          sst_q <= VSD_XFER;
          if (async_m ? sak_fall : bclk_rise) scnt_q <= 3'h1;
        end
        VSD_XFER: begin
          if (async_m ? sak_fall : (bclk_rise & ~sak_s))
            scnt_q <= scnt_q + 1'b1;
          if (scnt_q == CNT_W'(DMA_WORDS) && sak_s)          // [RL8]
            sst_q <= VSD_IDLE;
        end
        default: sst_q <= VSD_IDLE;
      endcase
    end
  end
endmodule

// ==== rtl/vsd_if.sv ====
interface vsd_if;
  import vsd_pkg::*;
  logic              memory_bus_clock;        // sync mode data clock
  logic [DIN_W-1:0]  din;                     // input data bus
  logic              register_write_strobe_n; // register write
  logic              video_dma_request_n;
  logic              video_dma_ack_n;
  logic              video_or_cursor_select;
  logic              sound_dma_request_n;
  logic              sound_dma_ack_n;
  logic              vram_clock_out_n;
  logic              vram_clock_return;
  logic              vram_transfer_status;
  logic              vertical_blank_flag;
  logic              line_sync;
  logic [1:0]        ext_register_outputs;
  logic [1:0]        port_source_select;
  // video controller end
  modport dev (
    input  memory_bus_clock, din, register_write_strobe_n,
    input  video_dma_ack_n, sound_dma_ack_n, vram_clock_return,
    input  vram_transfer_status, port_source_select,
    output video_dma_request_n, video_or_cursor_select,
    output sound_dma_request_n, vram_clock_out_n, vertical_blank_flag,
    output line_sync, ext_register_outputs
  );
  // memory controller end
  modport mc (
    output memory_bus_clock, din, register_write_strobe_n,
    output video_dma_ack_n, sound_dma_ack_n, vram_clock_return,
    output vram_transfer_status, port_source_select,
    input  video_dma_request_n, video_or_cursor_select,
    input  sound_dma_request_n, vram_clock_out_n, vertical_blank_flag,
    input  line_sync, ext_register_outputs
  );
endinterface

// ==== rtl/vsd_mem_ctrl.sv ====
// memory controller end: answers dma, writes registers
module vsd_mem_ctrl (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  vsd_if.mc                              bus,
  input  wire logic                      async_mode,
  input  wire logic                      wr_req,
  input  wire logic [vsd_pkg::REG_ADDR_W-1:0] wr_addr,
  input  wire logic [vsd_pkg::REG_DATA_W-1:0] wr_data,
  input  wire logic [vsd_pkg::DIN_W-1:0] dma_word,
  input  wire logic                      transfer_status,
  input  wire logic [1:0]                port_sel,
  output logic                           busy,
  output logic                           vram_transfer_cycle
);
  import vsd_pkg::*;
  localparam logic [CNT_W-1:0] PH_W = 3'h3; // last phase count; a phase lasts four clocks

  logic vrq_s, srq_s, vram_clock_return_s;
  vsd_sync2 u_vrq (.clk(clk), .rst_n(rst_n),
    .d(bus.video_dma_request_n), .q(vrq_s));
  vsd_sync2 u_srq (.clk(clk), .rst_n(rst_n),
    .d(bus.sound_dma_request_n), .q(srq_s));
  vsd_sync2 u_qck (.clk(clk), .rst_n(rst_n),
    .d(bus.vram_clock_out_n), .q(vram_clock_return_s));

  vsd_dma_state_t     st_q;
  logic [CNT_W-1:0]   beats_q, ph_q;
  logic               is_snd_q, bclk_q, ack_q;
  logic               qsf_q;
  logic               xfer_pend_q; // status edge not yet served

  assign busy = (st_q != VSD_IDLE);
  assign bus.vram_clock_return = ~vram_clock_return_s;                    // [RL15]
  assign bus.memory_bus_clock  = async_mode ? 1'b0 : bclk_q; // [RL22]
  assign bus.video_dma_ack_n   = is_snd_q | ~ack_q;
  assign bus.sound_dma_ack_n   = ~is_snd_q | ~ack_q;
  assign bus.port_source_select = port_sel;                  // [RL21]
  assign bus.vram_transfer_status = qsf_q;

  // answer one dma request at a time, four words each
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= VSD_IDLE;
      beats_q <= '0;
      ph_q <= '0;
      is_snd_q <= 1'b0;
      bclk_q <= 1'b0;
      ack_q <= 1'b0;
      bus.din <= '0;
      bus.register_write_strobe_n <= 1'b1;
      vram_transfer_cycle <= 1'b0;
      qsf_q <= 1'b0;
      xfer_pend_q <= 1'b0;
    end else begin
      qsf_q <= transfer_status;
      if (qsf_q != transfer_status) xfer_pend_q <= 1'b1;
      ph_q <= ph_q + 1'b1;
      if (ph_q == PH_W) begin
        ph_q <= '0;
        bclk_q <= ~bclk_q;
      end
      case (st_q)
        VSD_IDLE: begin
          bus.register_write_strobe_n <= 1'b1;
          vram_transfer_cycle <= 1'b0;
          if (!srq_s || !vrq_s) begin
            is_snd_q <= !srq_s;
            vram_transfer_cycle <= srq_s && bus.video_or_cursor_select
                                   && xfer_pend_q;           // [RL17]
            if (srq_s) xfer_pend_q <= (qsf_q != transfer_status);
            beats_q <= '0;
            ack_q <= 1'b1;                                   // [RL9] [RL11]
            ph_q <= '0;
            bclk_q <= 1'b0; // first bus clock rise takes word 0
            bus.din <= dma_word;
            st_q <= VSD_XFER;
          end else if (wr_req) begin
            bus.din <= '0;
            bus.din[REG_ADDR_LSB +: REG_ADDR_W] <= wr_addr;   // [RL4]
            bus.din[REG_DATA_W-1:0] <= wr_data;              // [RL23]
            bus.register_write_strobe_n <= 1'b0;
            ph_q <= '0;
            st_q <= VSD_REQ;
          end
        end
        VSD_REQ: if (ph_q == PH_W) begin                     // strobe hold
          bus.register_write_strobe_n <= 1'b1;
          st_q <= VSD_IDLE;
        end
        VSD_XFER: if (ph_q == PH_W) begin
          if (async_mode) ack_q <= ~ack_q;                   // [RL13]
          // next word after each ack pulse or bus clock fall
          if (async_mode ? ack_q : bclk_q) begin
            beats_q <= beats_q + 1'b1;
            bus.din <= dma_word;
            if (beats_q == CNT_W'(DMA_WORDS - 1)) begin      // [RL8] [RL12]
              ack_q <= 1'b0;
              st_q <= VSD_IDLE;
            end
          end
        end
        default: st_q <= VSD_IDLE;
      endcase
    end
  end
endmodule

// ==== rtl/vsd_pkg.sv ====
package vsd_pkg;
  // data bus and register write layout
  localparam int DIN_W        = 64;  // input data bus width
  localparam int REG_ADDR_W   = 8;   // register address field width
  localparam int REG_ADDR_LSB = 24;  // address sits above the data field
  localparam int REG_DATA_W   = 24;  // register value field width
  // dma shape
  localparam int DMA_WORDS    = 4;   // words per request of either kind
  localparam int CNT_W        = 3;   // word counter width
  localparam int FIFO_W       = 32;  // video word width held per beat
  localparam int FIFO_DEPTH   = 8;   // video fifo depth in words
  localparam int FIFO_AW      = 4;   // fifo pointer width (with wrap bit)
  localparam logic [FIFO_AW-1:0] FIFO_LOW = 4'h4; // refill threshold
  // register addresses (designer choice)
  localparam logic [REG_ADDR_W-1:0] ADDR_CONTROL  = 8'hE0;
  localparam logic [REG_ADDR_W-1:0] ADDR_EXTREG   = 8'hC0;
  localparam logic [REG_ADDR_W-1:0] ADDR_HSYNC_W  = 8'h84;
  localparam logic [REG_ADDR_W-1:0] ADDR_VDISP    = 8'hB0;
  localparam logic [REG_ADDR_W-1:0] ADDR_VTOTAL   = 8'hB4;
  localparam logic [REG_ADDR_W-1:0] ADDR_HTOTAL   = 8'h80;
  // control register fields
  localparam int CTL_PDOWN_BIT = 14;  // power-down flag
  localparam int CTL_ASYNC_BIT = 0;   // asynchronous bus mode
  localparam int CTL_VRAM_BIT  = 1;   // vram mode
  localparam int CTL_CURS_BIT  = 2;   // cursor fetch request
  localparam int CTL_SND_BIT   = 3;   // sound enable
  // external register fields
  localparam int EXT_SYNC_SEL_BIT = 16; // composite when set
  localparam int EXT_SYNC_POL_BIT = 17; // inverts line sync polarity when set
  localparam int TIMER_W = 12;          // raster timer width
  // dma engine states, one-hot encoded
  typedef enum logic [2:0] {
    VSD_IDLE = 3'b001,
    VSD_REQ  = 3'b010,
    VSD_XFER = 3'b100
  } vsd_dma_state_t;
endpackage

// ==== rtl/vsd_sync2.sv ====
// two-stage synchroniser for pins entering the clk domain
module vsd_sync2 (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);
  logic s1_q; // first stage, read only by second stage
  // two flops in series
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      q    <= 1'b0;
    end else begin
      s1_q <= d;
      q    <= s1_q;
    end
  end
endmodule
